/* src/bcc_pkg.sv */
// ****************************************************************
// constants of the commutation core
// ****************************************************************
package bcc_pkg;

   localparam int          CLK_MHZ      = 200;
   localparam int          CLK_PERIOD_NS = 5;

   // current limit blanking, a least time so it rounds up
   localparam int          BLANK_NS     = 300;
   localparam int          BLANK_CYC    = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int          BLANK_W      = 8;

   // sense path: full scale of the sense code in millivolts
   localparam int          SENSE_W      = 10;
   localparam int          SENSE_FS_MV  = 1000;
   localparam int          LIMIT_MV     = 515;
   localparam logic [9:0]  LIMIT_CODE   = 10'(LIMIT_MV * 1023 / SENSE_FS_MV);

   // phase error window under which the loop counts as locked
   localparam int          LOCK_WIN_CYC = 8;
   localparam int          WIDTH_W      = 16;

   // per-phase drive codes
   localparam logic [1:0]  DRV_OFF      = 2'h0;
   localparam logic [1:0]  DRV_HI       = 2'h1;
   localparam logic [1:0]  DRV_LO       = 2'h2;

   typedef enum logic [2:0] {
      ST_STOP  = 3'b001,
      ST_RUN   = 3'b010,
      ST_STALL = 3'b100
   } bcc_state_t;

   // hall pattern is {phase3, phase2, phase1}; result index 0 is phase 1
   function automatic logic [2:0][1:0] bcc_commutate(input logic [2:0] pat);
      logic [2:0][1:0] d;
      d = '{DRV_OFF, DRV_OFF, DRV_OFF};
      unique case (pat)
         3'b101:  d = '{DRV_OFF, DRV_HI,  DRV_LO};
         3'b001:  d = '{DRV_HI,  DRV_OFF, DRV_LO};
         3'b011:  d = '{DRV_HI,  DRV_LO,  DRV_OFF};
         3'b010:  d = '{DRV_OFF, DRV_LO,  DRV_HI};
         3'b110:  d = '{DRV_LO,  DRV_OFF, DRV_HI};
         3'b100:  d = '{DRV_LO,  DRV_HI,  DRV_OFF};
         default: d = '{DRV_OFF, DRV_OFF, DRV_OFF};
      endcase
      return d;
   endfunction

endpackage

/* src/bcc_pwm_if.sv */
`timescale 1ns/1ps
// ****************************************************************
// link between commutation core and pwm generator
// ****************************************************************
interface bcc_pwm_if #(parameter int PWM_W = 16);
   logic [PWM_W-1:0] period;
   logic [PWM_W-1:0] duty;
   logic             over_limit;
   logic             pwm_on;
   logic             limit_hit;

   modport ctl (output period, output duty, output over_limit, input pwm_on, input limit_hit);
   modport gen (input period, input duty, input over_limit, output pwm_on, output limit_hit);
endinterface

/* src/bcc_pwm_gen.sv */
`timescale 1ns/1ps
// ****************************************************************
// pwm period counter with blanked cycle-by-cycle current limit
// ****************************************************************
module bcc_pwm_gen
   import bcc_pkg::*;
#(
   parameter int PWM_W = 16
) (
   input wire logic clk,      // core clock
   input wire logic nrst,     // sync reset, active low
   bcc_pwm_if.gen   pif       // period, duty and limit link
);

   typedef struct packed {
      logic [PWM_W-1:0]   cnt;
      logic [BLANK_W-1:0] blank;
      logic               cut;
      logic               on;
      logic               hit;
   } bcc_pwm_st_t;

   bcc_pwm_st_t s_q;
   bcc_pwm_st_t s_d;
   logic        wrap;

   if (BLANK_CYC >= (1 << BLANK_W)) begin : g_chk
      $error("blanking count does not fit its counter");
   end

   assign wrap = (s_q.cnt >= pif.period - PWM_W'(1));

   always_comb begin
      s_d     = s_q;
      s_d.hit = 1'b0;
      s_d.cnt = wrap ? '0 : s_q.cnt + PWM_W'(1);
      if (wrap) begin
         s_d.blank = '0;
         s_d.cut   = 1'b0;
      end else begin
         if (s_q.on && s_q.blank < BLANK_W'(BLANK_CYC)) begin
            s_d.blank = s_q.blank + BLANK_W'(1);
         end
         // spikes inside the blanking window are ignored
         if (s_q.on && pif.over_limit && s_q.blank == BLANK_W'(BLANK_CYC)) begin
            s_d.cut = 1'b1;
            s_d.hit = 1'b1;
         end
      end
      s_d.on = (s_d.cnt < pif.duty) && !s_d.cut;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pif.pwm_on    = s_q.on;
   assign pif.limit_hit = s_q.hit;

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_blank;
      @(posedge clk) disable iff (!nrst)
      (s_q.on && pif.over_limit && !s_q.cut && s_q.blank < BLANK_W'(BLANK_CYC) && !wrap) |=> !s_q.cut;
   endproperty
   a_blank: assert property (p_blank) else $error("limit acted inside blanking");

   property p_cut;
      @(posedge clk) disable iff (!nrst)
      (s_q.on && pif.over_limit && s_q.blank == BLANK_W'(BLANK_CYC) && !wrap) |=> !pif.pwm_on ##0 pif.limit_hit;
   endproperty
   a_cut: assert property (p_cut) else $error("over limit did not end on time");

   sequence s_zero_duty;
      (pif.duty == '0) [*2];
   endsequence
   property p_duty;
      @(posedge clk) disable iff (!nrst)
      s_zero_duty |=> !pif.pwm_on;
   endproperty
   a_duty: assert property (p_duty) else $error("pwm on with zero duty");

endmodule

/* src/bcc_core.sv */
`timescale 1ns/1ps
module bcc_core
   import bcc_pkg::*;
#(
   parameter int PWM_W  = 16,
   parameter int HALL_W = 8,
   parameter int CNT_W  = 32
) (
   input  wire logic                 clk,                  // 200 MHz core clock
   input  wire logic                 nrst,                 // sync reset, active low
   input  wire logic [2:0][HALL_W-1:0] hall_pos,           // hall comparator positive inputs
   input  wire logic [2:0][HALL_W-1:0] hall_neg,           // hall comparator negative inputs
   input  wire logic                 direction_select,     // 1 forward table, 0 reverse
   input  wire logic                 run_stop_select,      // 1 stop, 0 run
   input  wire logic                 stop_brake_select,    // 1 free-run, 0 brake in stop
   input  wire logic                 stall_source_select,  // 1 lock detect, 0 speed pulse
   input  wire logic                 ref_clock,            // speed reference
   input  wire logic [PWM_W-1:0]     torque_command,       // torque code, larger means less duty
   input  wire logic [SENSE_W-1:0]   current_sense_input,  // sense resistor voltage code
   input  wire logic [PWM_W-1:0]     pwm_period_cycles,    // pwm period in clocks
   input  wire logic [CNT_W-1:0]     stall_cycles,         // stall protection time in clocks
   input  wire logic [CNT_W-1:0]     lock_mask_cycles,     // lock mask time in clocks
   output logic      [2:0]           phase_out_hs,         // high side gate, bit 0 is phase 1
   output logic      [2:0]           phase_out_ls,         // low side gate, bit 0 is phase 1
   output logic                      hall_bias_enable,     // hall bias current on
   output logic                      speed_pulse,          // speed pulse from hall phase 1
   output logic                      lock_detect,          // 1 when phase locked
   output logic                      phase_error_out,      // phase error pulse train
   output logic                      power_save,           // internal bias gated off
   output logic                      regulator_enable,     // regulator output kept on
   output logic                      stall_active          // stall protection tripped
);

   localparam logic [WIDTH_W-1:0] LOCK_WIN = WIDTH_W'(LOCK_WIN_CYC);
   localparam logic signed [PWM_W:0] TRIM_MAX = (PWM_W + 1)'(1 << (PWM_W - 1));

   if (PWM_W < 4 || PWM_W > 30 || HALL_W < 1 || CNT_W < 8) begin : g_chk
      $error("unsupported width parameter");
   end

   typedef struct packed {
      bcc_state_t               st;
      logic [2:0]               hall;
      logic                     sp_prev;
      logic                     ref_prev;
      logic                     up;
      logic                     dn;
      logic [WIDTH_W-1:0]       width;
      logic                     raw_lock;
      logic [CNT_W-1:0]         mask_cnt;
      logic                     lock;
      logic [CNT_W-1:0]         stall_cnt;
      logic signed [PWM_W:0]    trim;
      logic [PWM_W-1:0]         duty;
      logic [2:0]               hs;
      logic [2:0]               ls;
      logic                     hb;
      logic                     ps;
      logic                     pd;
   } bcc_core_st_t;

   bcc_core_st_t    s_q;
   bcc_core_st_t    s_d;
   logic            ref_rise;
   logic            sp_rise;
   logic            sp_toggle;
   logic            src_ok;
   logic            h1_raw;
   logic [2:0]      pattern;
   logic [2:0][1:0] drv;

   bcc_pwm_if #(.PWM_W(PWM_W)) pif ();

   bcc_pwm_gen #(.PWM_W(PWM_W)) u_pwm (
      .clk  (clk),
      .nrst (nrst),
      .pif  (pif.gen)
   );

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic hall_read(input logic [HALL_W-1:0] p, input logic [HALL_W-1:0] n);
      return p > n;
   endfunction

   // base duty falls as the torque code rises, then the loop trim is added
   function automatic logic [PWM_W-1:0] sat_duty(input logic [PWM_W-1:0] per,
                                                 input logic [PWM_W-1:0] tq,
                                                 input logic signed [PWM_W:0] tr);
      logic signed [PWM_W+1:0] sum;
      sum = '0;
      if (tq < per) begin
         sum = $signed({2'b00, per - tq});
      end
      sum = sum + (PWM_W + 2)'(tr);
      if (sum < 0) begin
         return '0;
      end else if (sum > $signed({2'b00, per})) begin
         return per;
      end
      return sum[PWM_W-1:0];
   endfunction

   assign h1_raw    = hall_read(hall_pos[0], hall_neg[0]);
   assign ref_rise  = ref_clock & ~s_q.ref_prev;
   assign sp_rise   = s_q.hall[0] & ~s_q.sp_prev;
   assign sp_toggle = s_q.hall[0] ^ s_q.sp_prev;
   assign src_ok    = stall_source_select ? s_q.lock : sp_toggle;
   assign pattern   = direction_select ? s_q.hall : ~s_q.hall;
   assign drv       = bcc_commutate(pattern);

   assign pif.period     = pwm_period_cycles;
   assign pif.duty       = s_q.duty;
   assign pif.over_limit = current_sense_input >= LIMIT_CODE;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      s_d = s_q;
      for (int i = 0; i < 3; i++) begin
         s_d.hall[i] = hall_read(hall_pos[i], hall_neg[i]);
      end
      s_d.sp_prev  = s_q.hall[0];
      s_d.ref_prev = ref_clock;

      // edge phase detector: up while reference leads, down while motor leads
      if (ref_rise && sp_rise) begin
         s_d.up = 1'b0;
         s_d.dn = 1'b0;
      end else if (ref_rise) begin
         s_d.up = ~s_q.dn;
         s_d.dn = 1'b0;
      end else if (sp_rise) begin
         s_d.dn = ~s_q.up;
         s_d.up = 1'b0;
      end
      s_d.pd = s_d.up;

      // a missing reference leaves down high, so the width runs out of lock
      if (s_q.up || s_q.dn) begin
         if (s_q.width != '1) begin
            s_d.width = s_q.width + WIDTH_W'(1);
         end
         if (s_q.width > LOCK_WIN) begin
            s_d.raw_lock = 1'b0;
         end
      end else begin
         s_d.width = '0;
      end
      if (sp_rise) begin
         s_d.raw_lock = (s_q.width <= LOCK_WIN);
      end

      // lock mask hides short locks while the loop hunts
      if (!s_q.raw_lock) begin
         s_d.mask_cnt = '0;
         s_d.lock     = 1'b0;
      end else if (s_q.mask_cnt < lock_mask_cycles) begin
         s_d.mask_cnt = s_q.mask_cnt + CNT_W'(1);
      end else begin
         s_d.lock = 1'b1;
      end

      // integrating trim closes the speed loop onto the reference
      if (s_q.up && s_q.trim < TRIM_MAX) begin
         s_d.trim = s_q.trim + (PWM_W + 1)'(1);
      end else if (s_q.dn && s_q.trim > -TRIM_MAX) begin
         s_d.trim = s_q.trim - (PWM_W + 1)'(1);
      end
      s_d.duty = sat_duty(pwm_period_cycles, torque_command, s_q.trim);

      // mode sequencing
      unique case (s_q.st)
         ST_STOP: begin
            s_d.stall_cnt = '0;
            if (!run_stop_select) begin
               s_d.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (run_stop_select) begin
               s_d.st = ST_STOP;
            end else if (src_ok) begin
               s_d.stall_cnt = '0;
            end else if (s_q.stall_cnt >= stall_cycles) begin
               s_d.st = ST_STALL;
            end else begin
               s_d.stall_cnt = s_q.stall_cnt + CNT_W'(1);
            end
         end
         ST_STALL: begin
            // only a stop releases the latched trip
            if (run_stop_select) begin
               s_d.st = ST_STOP;
            end
         end
      endcase
      s_d.hb = (s_d.st != ST_STOP);
      s_d.ps = (s_d.st == ST_STOP);

      // gates; each switch waits one clock for its partner to be off
      for (int i = 0; i < 3; i++) begin
         s_d.hs[i] = 1'b0;
         s_d.ls[i] = 1'b0;
         if (s_d.st == ST_RUN) begin
            if (drv[i] == DRV_HI) begin
               s_d.hs[i] = pif.pwm_on & ~s_q.ls[i];
               s_d.ls[i] = ~pif.pwm_on & ~s_q.hs[i];
            end else if (drv[i] == DRV_LO) begin
               s_d.ls[i] = ~s_q.hs[i];
            end
         end else if (s_d.st == ST_STOP) begin
            s_d.ls[i] = ~stop_brake_select & ~s_q.hs[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_q    <= '0;
         s_q.st <= ST_STOP;
         s_q.ps <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign phase_out_hs     = s_q.hs;
   assign phase_out_ls     = s_q.ls;
   assign hall_bias_enable = s_q.hb;
   assign speed_pulse      = s_q.hall[0];
   assign lock_detect      = s_q.lock;
   assign phase_error_out  = s_q.pd;
   assign power_save       = s_q.ps;
   assign regulator_enable = 1'b1;
   assign stall_active     = (s_q.st == ST_STALL);

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_stop_bias;
      @(posedge clk) disable iff (!nrst)
      run_stop_select |=> !hall_bias_enable && power_save;
   endproperty
   a_stop_bias: assert property (p_stop_bias) else $error("bias on while stopped");

   property p_run_bias;
      @(posedge clk) disable iff (!nrst)
      (!run_stop_select && s_q.st == ST_STOP) |=> hall_bias_enable && !power_save;
   endproperty
   a_run_bias: assert property (p_run_bias) else $error("bias off after start");

   sequence s_brake_hold;
      (run_stop_select && !stop_brake_select) [*3];
   endsequence
   property p_brake;
      @(posedge clk) disable iff (!nrst)
      s_brake_hold |=> (phase_out_ls == 3'h7) && (phase_out_hs == 3'h0);
   endproperty
   a_brake: assert property (p_brake) else $error("brake not applied in stop");

   sequence s_free_hold;
      (run_stop_select && stop_brake_select) [*2];
   endsequence
   property p_free;
      @(posedge clk) disable iff (!nrst)
      s_free_hold |=> (phase_out_ls == 3'h0) && (phase_out_hs == 3'h0);
   endproperty
   a_free: assert property (p_free) else $error("drive on during free run");

   property p_no_shoot;
      @(posedge clk) disable iff (!nrst)
      (phase_out_hs & phase_out_ls) == 3'h0 ##1 (phase_out_hs & $past(phase_out_ls)) == 3'h0;
   endproperty
   a_no_shoot: assert property (p_no_shoot) else $error("high and low side overlap");

   property p_stall_off;
      @(posedge clk) disable iff (!nrst)
      stall_active |=> phase_out_hs == 3'h0;
   endproperty
   a_stall_off: assert property (p_stall_off) else $error("high side on during stall");

   property p_speed;
      @(posedge clk) disable iff (!nrst)
      ##1 speed_pulse == $past(h1_raw);
   endproperty
   a_speed: assert property (p_speed) else $error("speed pulse not from phase one");

   property p_pd;
      @(posedge clk) disable iff (!nrst)
      (ref_rise && !sp_rise && !s_q.dn) |=> phase_error_out;
   endproperty
   a_pd: assert property (p_pd) else $error("phase error pulse missing");

   sequence s_pat_a;
      (s_q.st == ST_RUN && !run_stop_select && (direction_select ? s_q.hall == 3'b101 : s_q.hall == 3'b010)) [*3];
   endsequence
   property p_comm;
      @(posedge clk) disable iff (!nrst)
      s_pat_a |-> phase_out_ls[0] && !phase_out_hs[0] && !phase_out_hs[2] && !phase_out_ls[2];
   endproperty
   a_comm: assert property (p_comm) else $error("commutation table mismatch");

endmodule

/* sim/bcc_motor_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// hall sensor front of the motor
// ****************************************************************
module bcc_motor_model (
   input  wire logic [2:0]      hall_state, // magnet state, bit 0 is phase 1
   input  wire logic [5:0]      margin,     // comparator overdrive
   output logic      [2:0][7:0] pos,        // positive comparator inputs
   output logic      [2:0][7:0] neg         // negative comparator inputs
);
   // never equal: a tie would leave the decoded level to the comparator
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         neg[k] = 8'h80;
         pos[k] = hall_state[k] ? 8'h81 + 8'(margin) : 8'h7F - 8'(margin);
      end
   end
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
// ****************************************************************
// commutation core bench
// ****************************************************************
module testbench;
   import bcc_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, dir = 1'b1, run_stop = 1'b1, brake = 1'b1, src = 1'b0;
   logic [2:0] hall_state = 3'h0, hs, ls;
   logic [5:0] margin = 6'h0;
   logic [2:0][7:0] pos, neg;
   logic [15:0] torque = 16'h4, period = 16'h14;
   logic [9:0] sense = 10'h0;
   logic [31:0] stall_cyc = 32'hFFFFFF;
   logic bias, spd, lock, perr, psave, reg_en, stall;
   logic ref_clk = 1'b0;
   int pd_exp = 0, pd_seen = 0;
   int err_count = 0, num_checks = 0, seed = 32'hDE21, mx;
   // packed {phase3, phase2, phase1}, 1 high side, 2 low side, 0 off
   int fwd_tab[8] = '{0, 'h12, 'h09, 'h18, 'h24, 'h06, 'h21, 0};
   logic [2:0] rot[6] = '{3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
   always #2.5 clk = ~clk;
   // error pulse is a registered level, so look at it away from the launching edge
   always @(negedge clk) if (perr === 1'b1) pd_seen++;
   bcc_motor_model i_bcc_motor_model (.hall_state(hall_state), .margin(margin), .pos(pos), .neg(neg));
   bcc_core i_bcc_core (.clk(clk), .nrst(nrst), .hall_pos(pos), .hall_neg(neg), .direction_select(dir),
      .run_stop_select(run_stop), .stop_brake_select(brake), .stall_source_select(src), .ref_clock(ref_clk),
      .torque_command(torque), .current_sense_input(sense), .pwm_period_cycles(period),
      .stall_cycles(stall_cyc), .lock_mask_cycles(32'hA), .phase_out_hs(hs), .phase_out_ls(ls),
      .hall_bias_enable(bias), .speed_pulse(spd), .lock_detect(lock), .phase_error_out(perr),
      .power_save(psave), .regulator_enable(reg_en), .stall_active(stall));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic gates(input logic [2:0] p);
      int e, c, on;
      if (p[0] && !ref_clk) pd_exp++;
      hall_state = p;
      // reference edge lands one clock ahead of the motor edge, so the trim never drains the duty
      ref_clk = p[0];
      margin = 6'($random(seed));
      tick(5);
      chk("speed", p[0], spd);
      e = fwd_tab[dir ? p : ~p];
      on = 0;
      repeat (20) begin
         for (int k = 0; k < 3; k++) begin
            c = (e >> (2 * k)) & 3;
            if (c == 1) on += hs[k];
            if (c == 1) chk("overlap", 0, hs[k] & ls[k]);
            else chk("gate", (c == 2) ? 1 : 0, {hs[k], ls[k]});
         end
         tick(1);
      end
      chk("pwm_on", (e != 0) ? 1 : 0, on > 0);
   endtask
   task automatic max_run;
      int r;
      mx = 0;
      r = 0;
      repeat (450) begin
         tick(1);
         r = hs[0] ? r + 1 : 0;
         if (r > mx) mx = r;
      end
   endtask
   initial begin
      tick(6);
      nrst = 1'b1;
      tick(1);
      chk("rst", 32'h1, {hs, ls, bias, stall, psave});
      chk("reg", 1, reg_en);
      for (int b = 0; b < 2; b++) begin
         brake = b[0];
         tick(3);
         chk("stop", b ? 32'h1 : 32'h39, {hs, ls, bias, stall, psave});
      end
      $display("stop tests done");
      run_stop = 1'b0;
      tick(3);
      chk("run", 32'h2, {bias, psave});
      for (int d = 1; d >= 0; d--) begin
         dir = d[0];
         foreach (rot[i]) gates(rot[i]);
         gates(3'h0);
         gates(3'h7);
      end
      chk("lock", 1, lock);
      chk("pd_pulses", pd_exp, pd_seen);
      $display("commutation tests done");
      dir = 1'b1;
      hall_state = 3'h2;
      ref_clk = 1'b0;
      period = 16'hC8;
      torque = 16'h0;
      sense = 10'h3FF;
      tick(10);
      max_run;
      chk("blank_run", 1, mx >= BLANK_CYC && mx <= BLANK_CYC + 2);
      sense = 10'h0;
      max_run;
      chk("free_run", 1, mx > BLANK_CYC + 2);
      torque = period;
      max_run;
      chk("torque", 1, mx < 10);
      $display("current limit tests done");
      for (int s = 0; s < 2; s++) begin
         run_stop = 1'b1;
         stall_cyc = 32'h32;
         src = s[0];
         hall_state = 3'h2;
         tick(3);
         run_stop = 1'b0;
         // one phase-1 edge with the reference gone: the loop falls out of lock
         hall_state = 3'h3;
         tick(40);
         chk("stall_early", 0, stall);
         tick(25);
         chk("stall", 32'h2, {hs, stall, lock});
         run_stop = 1'b1;
         tick(3);
         chk("release", 0, stall);
      end
      $display("stall tests done");
      complete_run;
   end
   initial begin
      #100000;
      err_count++;
      complete_run;
   end
endmodule
